/* File: em_pkg.sv */
package em_pkg;
	// one-second measurement window
	localparam int unsigned SECOND_NS = 1000000000;
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;

	// widths
	localparam int unsigned RATE_W = 32;
	localparam int unsigned TIME_W = 16;
	localparam int unsigned BYTES_W = 16;

	// energy management indicator carried by the bonding change
	localparam logic [1:0] IND_NONE = 2'h0;
	localparam logic [1:0] IND_ONE_PAIR = 2'h1;
	localparam logic [1:0] IND_LIGHT_SLEEP = 2'h2;

	// requested power mode in a request (same coding as the indicator)
	localparam logic [1:0] PMODE_NORMAL = 2'h0;

	// response codes
	localparam logic [7:0] RSP_OK = 8'h01;
	localparam logic [7:0] RSP_REJ_TEMP = 8'h02;
	localparam logic [7:0] RSP_REJ_DISABLED = 8'h03;
	localparam logic [7:0] RSP_REJ_MASKS = 8'h04;

	// feature bit positions in capability and control words
	localparam int unsigned FEAT_ONE_PAIR = 0;
	localparam int unsigned FEAT_LIGHT_SLEEP = 1;

	// guaranteed reserved rate limit while in a mode
	localparam logic [15:0] RESERVED_LIMIT_KBPS = 16'h00c8;

	// reset values
	localparam logic [RATE_W-1:0] RATE_RST = 32'h0;
	localparam logic [TIME_W-1:0] TIME_RST = 16'h0;
	localparam logic [7:0] CODE_RST = 8'h00;

	typedef struct packed {
		logic [RATE_W-1:0] us_entry_rate;
		logic [RATE_W-1:0] ds_entry_rate;
		logic [RATE_W-1:0] us_exit_rate;
		logic [RATE_W-1:0] ds_exit_rate;
		logic [TIME_W-1:0] us_entry_time;
		logic [TIME_W-1:0] ds_entry_time;
		logic [TIME_W-1:0] us_exit_time;
		logic [TIME_W-1:0] ds_exit_time;
	} thr_set_t;
endpackage : em_pkg

/* File: em_link_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface em_link_if;
	// energy request, held until the response
	logic req_valid;
	logic [1:0] req_mode;
	// energy response, one-cycle pulse
	logic rsp_valid;
	logic [7:0] rsp_code;
	// bonding change, held until acknowledged
	logic dbc_valid;
	logic [1:0] dbc_indicator;
	logic dbc_ack;

	modport modem (
		output req_valid,
		output req_mode,
		input rsp_valid,
		input rsp_code,
		input dbc_valid,
		input dbc_indicator,
		output dbc_ack
	);

	modport headend (
		input req_valid,
		input req_mode,
		output rsp_valid,
		output rsp_code,
		output dbc_valid,
		output dbc_indicator,
		input dbc_ack
	);
endinterface : em_link_if
`default_nettype wire

/* File: em_headend_end.sv */
`timescale 1ns/10ps
`default_nettype none
module em_headend_end (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// link to modem
	em_link_if.headend link,
	// domain policy
	input wire logic one_pair_enabled,
	input wire logic light_sleep_enabled,
	input wire logic masks_met,
	input wire logic strict_masks,
	input wire logic poll_conflict,
	input wire logic dsa_masks_ok,
	input wire logic [15:0] min_rate_kbps,
	// status
	output logic modem_in_mode,
	output logic [1:0] modem_mode,
	output logic mask_warning,
	output logic drop_reserved,
	output logic [7:0] last_code
);
	typedef enum logic [1:0] {H_IDLE, H_RSP, H_DBC} h_state_t;
	h_state_t state;
	logic [7:0] code_q;
	logic [1:0] ind_q;
	logic dbc_after;

	wire req_entry = link.req_mode != em_pkg::PMODE_NORMAL;
	wire mode_enabled = (link.req_mode == em_pkg::IND_LIGHT_SLEEP) ? light_sleep_enabled
		: one_pair_enabled;
	wire [7:0] dec_code = !req_entry ? em_pkg::RSP_OK
		: !mode_enabled ? em_pkg::RSP_REJ_DISABLED
		: poll_conflict ? em_pkg::RSP_REJ_TEMP
		: (!masks_met && strict_masks) ? em_pkg::RSP_REJ_MASKS
		: em_pkg::RSP_OK;
	wire take_req = state == H_IDLE && link.req_valid;
	// forced exit: satisfiable flow addition, or one-pair feature switched off
	wire force_exit = state == H_IDLE && !link.req_valid && modem_in_mode
		&& (dsa_masks_ok
		|| (modem_mode == em_pkg::IND_ONE_PAIR && !one_pair_enabled));
	wire dbc_done = state == H_DBC && link.dbc_ack;

	assign link.rsp_valid = state == H_RSP;
	assign link.rsp_code = code_q;
	assign link.dbc_valid = state == H_DBC;
	assign link.dbc_indicator = ind_q;
	assign drop_reserved = modem_in_mode && min_rate_kbps > em_pkg::RESERVED_LIMIT_KBPS;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state <= H_IDLE;
			code_q <= em_pkg::CODE_RST;
			ind_q <= em_pkg::IND_NONE;
			dbc_after <= 1'b0;
			last_code <= em_pkg::CODE_RST;
			mask_warning <= 1'b0;
		end else begin
			mask_warning <= 1'b0;
			case (state)
				H_IDLE: begin
					if (take_req) begin
						code_q <= dec_code;
						ind_q <= link.req_mode;
						dbc_after <= dec_code == em_pkg::RSP_OK;
						mask_warning <= req_entry && dec_code == em_pkg::RSP_OK && !masks_met;
						state <= H_RSP;
					end else if (force_exit) begin
						ind_q <= em_pkg::IND_NONE;
						state <= H_DBC;
					end
				end
				H_RSP: begin
					last_code <= code_q;
					// accepted requests finish even if the feature went off meanwhile
					state <= dbc_after ? H_DBC : H_IDLE;
				end
				H_DBC: begin
					if (link.dbc_ack) begin
						state <= H_IDLE;
					end
				end
				default: begin
					state <= H_IDLE;
				end
			endcase
		end
	end

	// head-end view of the modem mode, updated when the change completes
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			modem_in_mode <= 1'b0;
			modem_mode <= em_pkg::IND_NONE;
		end else if (dbc_done) begin
			modem_in_mode <= ind_q != em_pkg::IND_NONE;
			modem_mode <= ind_q;
		end
	end
	// masks_met reflects channel choice honouring masks where reachable channels allow
endmodule : em_headend_end
`default_nettype wire

/* File: em_modem_end.sv */
`timescale 1ns/10ps
`default_nettype none
module em_modem_end #(
	parameter int unsigned SECOND_CYCLES = em_pkg::SECOND_CYCLES
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// link to head-end
	em_link_if.modem link,
	// provisioning
	input wire logic operational,
	input wire logic [1:0] cap_confirm,
	input wire logic [1:0] cfg_enable,
	input wire logic primary_ofdm,
	input wire em_pkg::thr_set_t thr_one_pair,
	input wire em_pkg::thr_set_t thr_light_sleep,
	input wire logic [15:0] cycle_period_s,
	// forwarded upstream traffic, already rate limited
	input wire logic us_valid,
	input wire logic [15:0] us_bytes,
	input wire logic us_mgmt,
	// forwarded downstream traffic at the MAC interface
	input wire logic ds_valid,
	input wire logic [15:0] ds_bytes,
	input wire logic ds_mgmt,
	// status
	output logic feature_on,
	output logic in_mode,
	output logic [1:0] em_mode,
	output logic [31:0] us_rate,
	output logic [31:0] ds_rate,
	output logic [7:0] last_code
);
	typedef enum logic {ST_IDLE, ST_WAIT_RSP} m_state_t;
	m_state_t state;
	logic [1:0] req_mode_q;
	logic [31:0] sec_cnt;
	logic [15:0] cyc_left;
	logic [31:0] acc [2];
	logic [31:0] rate_q [2];
	logic [15:0] streak [2];
	logic [1:0] met;
	logic [1:0] cnt_en;
	logic [15:0] bytes_in [2];
	logic [31:0] ent_rate [2];
	logic [31:0] ext_rate [2];
	logic [15:0] ent_time [2];
	logic [15:0] ext_time [2];

	// feature and threshold selection
	wire [1:0] feat_ok = cap_confirm & cfg_enable;
	wire sel_ls = primary_ofdm;
	assign feature_on = sel_ls ? feat_ok[em_pkg::FEAT_LIGHT_SLEEP]
		: feat_ok[em_pkg::FEAT_ONE_PAIR];
	wire em_pkg::thr_set_t thr = sel_ls ? thr_light_sleep : thr_one_pair;
	wire monitoring = operational && feature_on;

	wire tick = monitoring && sec_cnt == SECOND_CYCLES - 1;

	assign cnt_en[0] = us_valid && !us_mgmt;
	assign cnt_en[1] = ds_valid && !ds_mgmt;
	assign bytes_in[0] = us_bytes;
	assign bytes_in[1] = ds_bytes;
	assign ent_rate[0] = thr.us_entry_rate;
	assign ent_rate[1] = thr.ds_entry_rate;
	assign ext_rate[0] = thr.us_exit_rate;
	assign ext_rate[1] = thr.ds_exit_rate;
	assign ent_time[0] = thr.us_entry_time;
	assign ent_time[1] = thr.ds_entry_time;
	assign ext_time[0] = thr.us_exit_time;
	assign ext_time[1] = thr.ds_exit_time;
	assign us_rate = rate_q[0];
	assign ds_rate = rate_q[1];

	// request decision
	wire want_entry = !in_mode && met == 2'b11 && cyc_left == em_pkg::TIME_RST;
	wire want_exit = in_mode && met != 2'b00;
	wire req_fire = state == ST_IDLE && monitoring && (want_entry || want_exit);

	// bonding change: completes in the cycle it is offered
	wire dbc_enter = link.dbc_valid && (link.dbc_indicator == em_pkg::IND_ONE_PAIR
		|| link.dbc_indicator == em_pkg::IND_LIGHT_SLEEP);
	wire dbc_leave = link.dbc_valid && link.dbc_indicator == em_pkg::IND_NONE;
	wire mode_flip = (dbc_enter && !in_mode) || (dbc_leave && in_mode);

	assign link.dbc_ack = link.dbc_valid;
	assign link.req_valid = state == ST_WAIT_RSP;
	assign link.req_mode = req_mode_q;

	// one-second window timer
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sec_cnt <= em_pkg::RATE_RST;
		end else if (!monitoring || tick) begin
			sec_cnt <= em_pkg::RATE_RST;
		end else begin
			sec_cnt <= sec_cnt + 32'h1;
		end
	end

	// per-direction counting and consecutive-second streaks
	for (genvar d = 0; d < 2; d++) begin : g_dir
		wire [31:0] take = cnt_en[d] ? {16'h0, bytes_in[d]} : 32'h0;
		wire [31:0] sample = acc[d] + take;
		wire pass = in_mode ? (sample > ext_rate[d]) : (sample < ent_rate[d]);
		wire [15:0] need = in_mode ? ext_time[d] : ent_time[d];

		assign met[d] = streak[d] >= need;

		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				acc[d] <= em_pkg::RATE_RST;
				rate_q[d] <= em_pkg::RATE_RST;
			end else if (!monitoring || tick) begin
				acc[d] <= em_pkg::RATE_RST;
				if (tick) begin
					rate_q[d] <= sample;
				end
			end else begin
				acc[d] <= sample;
			end
		end

		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				streak[d] <= em_pkg::TIME_RST;
			end else if (!monitoring || mode_flip || req_fire) begin
				streak[d] <= em_pkg::TIME_RST;
			end else if (tick) begin
				if (!pass) begin
					streak[d] <= em_pkg::TIME_RST;
				end else if (streak[d] != 16'hffff) begin
					streak[d] <= streak[d] + 16'h1;
				end
			end
		end
	end

	// cycle-period timer, counted in seconds from each entry request
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cyc_left <= em_pkg::TIME_RST;
		end else if (req_fire && want_entry) begin
			cyc_left <= cycle_period_s;
		end else if (tick && cyc_left != em_pkg::TIME_RST) begin
			cyc_left <= cyc_left - 16'h1;
		end
	end

	// request handshake
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state <= ST_IDLE;
			req_mode_q <= em_pkg::PMODE_NORMAL;
			last_code <= em_pkg::CODE_RST;
		end else begin
			case (state)
				ST_IDLE: begin
					if (req_fire) begin
						if (want_entry) begin
							req_mode_q <= sel_ls ? em_pkg::IND_LIGHT_SLEEP
								: em_pkg::IND_ONE_PAIR;
						end else begin
							req_mode_q <= em_pkg::PMODE_NORMAL;
						end
						state <= ST_WAIT_RSP;
					end
				end
				ST_WAIT_RSP: begin
					if (link.rsp_valid) begin
						last_code <= link.rsp_code;
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// mode changes only on a completed bonding change
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			in_mode <= 1'b0;
			em_mode <= em_pkg::IND_NONE;
		end else if (dbc_enter) begin
			in_mode <= 1'b1;
			em_mode <= link.dbc_indicator;
		end else if (dbc_leave) begin
			in_mode <= 1'b0;
			em_mode <= em_pkg::IND_NONE;
		end
	end
endmodule : em_modem_end
`default_nettype wire

/* File: em_link_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module em_link_checker (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// link
	input wire logic req_valid,
	input wire logic [1:0] req_mode,
	input wire logic rsp_valid,
	input wire logic [7:0] rsp_code,
	input wire logic dbc_valid,
	input wire logic [1:0] dbc_indicator,
	input wire logic dbc_ack
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	wire ok_rsp = rsp_valid && rsp_code == em_pkg::RSP_OK;
	AST_RSP_AFTER_REQ: assert property (
		rsp_valid |-> $past(req_valid)) else $error("response without request");
	AST_RSP_PULSE: assert property (
		rsp_valid |=> !rsp_valid) else $error("response longer than one cycle");
	AST_REQ_HOLD: assert property (
		req_valid && !rsp_valid |=> req_valid && $stable(req_mode)) else $error("request dropped");
	AST_REQ_DROP: assert property (
		rsp_valid |=> !req_valid) else $error("request held after response");
	AST_ACK_SAME: assert property (
		dbc_valid |-> dbc_ack) else $error("change not acknowledged");
	AST_DBC_PULSE: assert property (
		dbc_valid |=> !dbc_valid) else $error("change held too long");
	AST_ENTRY_DBC: assert property (
		ok_rsp && req_mode != em_pkg::PMODE_NORMAL |=> dbc_valid && dbc_indicator == $past(req_mode))
		else $error("entry change missing");
	AST_EXIT_DBC: assert property (
		ok_rsp && req_mode == em_pkg::PMODE_NORMAL |=> dbc_valid && dbc_indicator == em_pkg::IND_NONE)
		else $error("exit change missing");
	AST_REJ_NO_DBC: assert property (
		rsp_valid && !ok_rsp |=> !dbc_valid) else $error("change after reject");
endmodule : em_link_checker
`default_nettype wire

/* File: energy_mode_threshold_monitor_test.sv */
`timescale 1ns/10ps
`default_nettype none
module energy_mode_threshold_monitor_test;
	typedef struct packed {
		logic ofdm;
		logic pair_en;
		logic poll;
		logic masks;
		logic strict;
		logic warn;
		logic [7:0] code;
		logic [1:0] mode;
	} row_t;
	localparam int unsigned WIN = 10;
	row_t rows [6] = '{'{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 8'h01, 2'h1},
		'{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 8'h01, 2'h2},
		'{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 8'h03, 2'h0},
		'{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 8'h02, 2'h0},
		'{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 8'h04, 2'h0},
		'{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 8'h01, 2'h1}};
	logic ref_clk, rst, operational, primary_ofdm, us_valid, us_mgmt, ds_valid, ds_mgmt;
	logic one_pair_enabled, poll_conflict, feature_on, in_mode, mask_warning, drop_reserved;
	logic h_in_mode;
	logic masks_met, strict_masks, dsa_masks_ok;
	logic [1:0] cap_confirm, cfg_enable, em_mode, h_mode;
	logic [15:0] us_bytes, ds_bytes, min_rate_kbps, cycle_s;
	logic [31:0] us_rate, ds_rate;
	logic [7:0] m_code, h_code;
	em_pkg::thr_set_t thr;
	int failures = 0;
	int checks = 0;
	int cycles = 0;
	em_link_if link ();
	em_modem_end #(.SECOND_CYCLES(WIN)) i_em_modem_end (.ref_clk(ref_clk), .rst(rst),
		.link(link.modem), .operational(operational), .cap_confirm(cap_confirm),
		.cfg_enable(cfg_enable), .primary_ofdm(primary_ofdm), .thr_one_pair(thr),
		.thr_light_sleep(thr), .cycle_period_s(cycle_s), .us_valid(us_valid),
		.us_bytes(us_bytes), .us_mgmt(us_mgmt), .ds_valid(ds_valid), .ds_bytes(ds_bytes),
		.ds_mgmt(ds_mgmt), .feature_on(feature_on), .in_mode(in_mode), .em_mode(em_mode),
		.us_rate(us_rate), .ds_rate(ds_rate), .last_code(m_code));
	em_headend_end i_em_headend_end (.ref_clk(ref_clk), .rst(rst), .link(link.headend),
		.one_pair_enabled(one_pair_enabled), .light_sleep_enabled(1'b1), .masks_met(masks_met),
		.strict_masks(strict_masks), .poll_conflict(poll_conflict), .dsa_masks_ok(dsa_masks_ok),
		.min_rate_kbps(min_rate_kbps), .modem_in_mode(h_in_mode), .modem_mode(h_mode),
		.mask_warning(mask_warning), .drop_reserved(drop_reserved), .last_code(h_code));
	em_link_checker i_em_link_checker (.ref_clk(ref_clk), .rst(rst),
		.req_valid(link.req_valid), .req_mode(link.req_mode), .rsp_valid(link.rsp_valid),
		.rsp_code(link.rsp_code), .dbc_valid(link.dbc_valid),
		.dbc_indicator(link.dbc_indicator), .dbc_ack(link.dbc_ack));
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			failures++;
			end_of_test();
		end
	end
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_val
	task automatic do_reset();
		rst = 1'b1;
		repeat (4) @(negedge ref_clk);
		rst = 1'b0;
	endtask : do_reset
	// bounded wait for the one-cycle response pulse
	task automatic wait_rsp();
		int n;
		n = 0;
		while (link.rsp_valid !== 1'b1 && n < 200) begin
			@(negedge ref_clk);
			n++;
		end
		chk_val(n < 200, 1);
	endtask : wait_rsp
	task automatic end_of_test();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_of_test
	initial begin
		rst = 1'b1;
		{operational, us_valid, us_mgmt, ds_valid} = 4'h8;
		{masks_met, strict_masks, dsa_masks_ok} = 3'h4;
		cycle_s = 16'h0000;
		{primary_ofdm, one_pair_enabled, poll_conflict, ds_mgmt} = 4'h1;
		{cap_confirm, cfg_enable} = 4'hf;
		us_bytes = 16'h00c8;
		ds_bytes = 16'hffff;
		min_rate_kbps = 16'h00c9;
		thr = '{32'h64, 32'h64, 32'h3e8, 32'h3e8, 16'h2, 16'h2, 16'h2, 16'h2};
		foreach (rows[i]) begin
			primary_ofdm = rows[i].ofdm;
			one_pair_enabled = rows[i].pair_en;
			poll_conflict = rows[i].poll;
			masks_met = rows[i].masks;
			strict_masks = rows[i].strict;
			do_reset();
			chk_val(feature_on, 1'b1);
			wait_rsp();
			chk_val(link.rsp_code, rows[i].code);
			chk_val(mask_warning, rows[i].warn);
			repeat (3) @(negedge ref_clk);
			chk_val(em_mode, rows[i].mode);
			chk_val(h_mode, rows[i].mode);
			chk_val(m_code, rows[i].code);
			if (rows[i].mode != 2'h0) begin
				chk_val(drop_reserved, 1'b1);
				{us_valid, ds_valid} = 2'h3;
				wait_rsp();
				chk_val(us_rate, WIN * 200);
				chk_val(ds_rate, 0);
				repeat (3) @(negedge ref_clk);
				chk_val(in_mode, 1'b0);
				chk_val(h_in_mode, 1'b0);
				{us_valid, ds_valid} = 2'h0;
			end
		end
		// forced exits: satisfiable flow addition, then one-pair feature switched off
		{masks_met, strict_masks} = 2'h2;
		for (int k = 0; k < 2; k++) begin
			{primary_ofdm, one_pair_enabled, poll_conflict} = 3'h2;
			do_reset();
			wait_rsp();
			repeat (3) @(negedge ref_clk);
			chk_val(in_mode, 1'b1);
			min_rate_kbps = 16'h00c8;
			@(negedge ref_clk);
			chk_val(drop_reserved, 1'b0);
			min_rate_kbps = 16'h00c9;
			if (k == 0) begin
				dsa_masks_ok = 1'b1;
				repeat (3) @(negedge ref_clk);
				chk_val(h_in_mode, 1'b0);
			end else begin
				one_pair_enabled = 1'b0;
				repeat (3) @(negedge ref_clk);
				chk_val(h_in_mode, 1'b0);
			end
			chk_val(in_mode, 1'b0);
			dsa_masks_ok = 1'b0;
		end
		// cycle-period timer holds back the next entry request for three windows
		cycle_s = 16'h0003;
		do_reset();
		wait_rsp();
		repeat (2 * WIN) @(negedge ref_clk);
		chk_val(link.req_valid, 1'b0);
		wait_rsp();
		chk_val(link.rsp_code, 8'h03);
		cycle_s = 16'h0000;
		// management traffic upstream is never counted
		{us_valid, us_mgmt} = 2'h3;
		do_reset();
		repeat (3 * WIN) @(negedge ref_clk);
		chk_val(us_rate, 0);
		{us_valid, us_mgmt} = 2'h0;
		operational = 1'b0;
		do_reset();
		repeat (5 * WIN) @(negedge ref_clk);
		chk_val(m_code, 8'h00);
		operational = 1'b1;
		{cap_confirm, cfg_enable} = 4'h9;
		do_reset();
		repeat (5 * WIN) @(negedge ref_clk);
		chk_val(feature_on, 1'b0);
		chk_val(m_code, 8'h00);
		end_of_test();
	end
endmodule : energy_mode_threshold_monitor_test
`default_nettype wire
